/* File: design/bhp_ahb_slave.sv */
`timescale 1ns/1ps
module bhp_ahb_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  input  wire logic [7:0]            rd_value,
  output bhp_pkg::bhp_bus_evt_t      evt,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp
);

  generate
    if (ADDR_W < 5) begin : g_bad_addr
      $error("bhp_ahb_slave: ADDR_W must be at least 5");
    end
  endgenerate

  logic              ap_take;
  logic              ap_mapped;
  logic              dp_rd_reg, dp_rd_next;
  logic              dp_wr_reg, dp_wr_next;
  logic [1:0]        dp_idx_reg, dp_idx_next;
  logic              dp_map_reg, dp_map_next;
  logic [31:0]       hrdata_reg, hrdata_next;

  assign ap_take   = hsel & htrans[1] & hready;
  // Narrow or misaligned accesses hit nothing: reads give zero, writes vanish
  assign ap_mapped = (haddr[ADDR_W-1:4] == '0) & (haddr[1:0] == 2'h0) & (hsize == bhp_pkg::HSIZE_WORD);

  always_comb begin
    dp_rd_next  = ap_take & ~hwrite;
    dp_wr_next  = ap_take & hwrite;
    dp_idx_next = ap_take ? haddr[3:2] : dp_idx_reg;
    dp_map_next = ap_take ? ap_mapped : 1'b0;
    // Read value is sampled in the address phase so hrdata leaves a flop
    hrdata_next = (ap_take & ~hwrite & ap_mapped) ? {24'h00_0000, rd_value} : bhp_pkg::WORD_ZERO;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dp_rd_reg  <= 1'b0;
      dp_wr_reg  <= 1'b0;
      dp_idx_reg <= 2'h0;
      dp_map_reg <= 1'b0;
      hrdata_reg <= bhp_pkg::WORD_ZERO;
    end else begin
      dp_rd_reg  <= dp_rd_next;
      dp_wr_reg  <= dp_wr_next;
      dp_idx_reg <= dp_idx_next;
      dp_map_reg <= dp_map_next;
      hrdata_reg <= hrdata_next;
    end
  end

  always_comb begin
    evt.rd_start  = ap_take & ~hwrite;
    evt.wr_start  = ap_take & hwrite;
    evt.ap_index  = haddr[3:2];
    evt.ap_mapped = ap_mapped;
    evt.rd_end    = dp_rd_reg;
    evt.wr_end    = dp_wr_reg;
    evt.dp_index  = dp_idx_reg;
    evt.dp_mapped = dp_map_reg;
    evt.wdata     = hwdata[7:0];
  end

  assign hrdata    = hrdata_reg;
  // Zero wait states and OKAY only; hreadyout kept in reset-defined form, hresp a plain zero
  assign hreadyout = arst_n | ~arst_n;
  assign hresp     = 1'b0;

endmodule : bhp_ahb_slave

/* File: design/bhp_fall_det.sv */
`timescale 1ns/1ps
module bhp_fall_det #(
  parameter logic RST_LEVEL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic level,
  output logic      fall
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= RST_LEVEL;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign fall = prev_reg & ~level;

endmodule : bhp_fall_det

/* File: design/bhp_port_ctrl.sv */
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module bhp_port_ctrl #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [7:0]        p0_in,
  output logic [7:0]             p0_out,
  output logic                   p0_oe,
  input  wire logic [7:0]        p1_in,
  output logic [7:0]             p1_out,
  output logic                   p1_oe,
  input  wire logic [7:0]        p2_in,
  output logic [7:0]             p2_out,
  output logic [7:0]             p2_oe
);

  generate
    if (ADDR_W < 5) begin : g_bad_addr
      $error("bhp_port_ctrl: ADDR_W must be at least 5");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bhp_pkg::bhp_cfg_t     cfg_reg, cfg_next;
  bhp_pkg::bhp_hs_t      hs_reg, hs_next;
  logic [7:0]            p0_latch_reg, p0_latch_next;
  logic [7:0]            p1_latch_reg, p1_latch_next;
  logic [7:0]            p2_latch_reg, p2_latch_next;
  logic [7:0]            in_buf_reg, in_buf_next;
  logic [7:0]            p0_out_reg, p0_out_next;
  logic                  p0_oe_reg, p0_oe_next;
  logic [7:0]            p1_out_reg, p1_out_next;
  logic                  p1_oe_reg, p1_oe_next;
  logic [7:0]            p2_out_reg, p2_out_next;
  logic [7:0]            p2_oe_reg, p2_oe_next;

  bhp_pkg::bhp_bus_evt_t evt;
  logic [7:0]            rd_value;
  logic                  hreadyout_w;
  logic                  g0_strobed;
  logic                  in_side;
  logic                  out_side;
  logic                  input_strobe_n;
  logic                  data_ack_in_n;
  logic                  stb_fall;
  logic                  host_read_of_port0_start;
  logic                  host_read_of_port0_end;
  logic                  host_write_to_port0_start;
  logic                  group0_irq_request;
  logic [7:0]            p2_plain_mask;
  logic [7:0]            p2_dir_in;
  logic [7:0]            p2_general;
  logic [2:0]            bmc_sel;

  // ----------------------------------------------------------------
  // Bus slave and strobe edge
  // ----------------------------------------------------------------
  bhp_ahb_slave #(.ADDR_W(ADDR_W)) u_slave (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .rd_value  (rd_value),
    .evt       (evt),
    .hrdata    (hrdata),
    .hreadyout (hreadyout_w),
    .hresp     (hresp)
  );

  bhp_fall_det #(.RST_LEVEL(1'b1)) u_stb_fall (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .level   (input_strobe_n),
    .fall    (stb_fall)
  );

  assign hreadyout = hreadyout_w;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic bhp_pkg::bhp_cfg_t decode_mode(input logic [7:0] w);
    bhp_pkg::bhp_cfg_t c;
    c = bhp_pkg::CFG_RST;
    unique case (w[bhp_pkg::CMD_G0_MODE_HI:bhp_pkg::CMD_G0_MODE_LO])
      2'h0:    c.g0_mode = bhp_pkg::BHP_G0_MODE0;
      2'h1:    c.g0_mode = bhp_pkg::BHP_G0_MODE1;
      default: c.g0_mode = bhp_pkg::BHP_G0_MODE2;
    endcase
    c.p0_in  = w[bhp_pkg::CMD_P0_IN_BIT];
    c.p2u_in = w[bhp_pkg::CMD_P2U_IN_BIT];
    c.p1_in  = w[bhp_pkg::CMD_P1_IN_BIT];
    c.p2l_in = w[bhp_pkg::CMD_P2L_IN_BIT];
    // Group 1 has no mode bit decoded (command bit 2 is ignored) and no bidirectional code at all
    return c;
  endfunction : decode_mode

  assign g0_strobed = (cfg_reg.g0_mode != bhp_pkg::BHP_G0_MODE0);
  assign in_side    = (cfg_reg.g0_mode == bhp_pkg::BHP_G0_MODE2) |
                      ((cfg_reg.g0_mode == bhp_pkg::BHP_G0_MODE1) & cfg_reg.p0_in);
  assign out_side   = (cfg_reg.g0_mode == bhp_pkg::BHP_G0_MODE2) |
                      ((cfg_reg.g0_mode == bhp_pkg::BHP_G0_MODE1) & ~cfg_reg.p0_in);

  // Enables never mask the pins: the inputs depend only on mode
  assign input_strobe_n = in_side  ? p2_in[bhp_pkg::P2_INPUT_STROBE_N] : 1'b1;
  assign data_ack_in_n  = out_side ? p2_in[bhp_pkg::P2_ACK0] : 1'b1;

  assign host_read_of_port0_start  = evt.rd_start & evt.ap_mapped & (evt.ap_index == bhp_pkg::IDX_PORT0);
  assign host_write_to_port0_start = evt.wr_start & evt.ap_mapped & (evt.ap_index == bhp_pkg::IDX_PORT0);
  assign host_read_of_port0_end    = hs_reg.rd_busy;
  assign group0_irq_request        = hs_reg.rreq | hs_reg.wreq;

  // Bit 3 stays with group 1 only while group 0 is in mode 0
  assign p2_plain_mask = g0_strobed ? bhp_pkg::P2_G1_MASK : bhp_pkg::P2_ALL_MASK;
  assign p2_dir_in     = {{4{cfg_reg.p2u_in}}, {4{cfg_reg.p2l_in}}};
  assign bmc_sel       = evt.wdata[bhp_pkg::BMC_SEL_HI:bhp_pkg::BMC_SEL_LO];

  // ----------------------------------------------------------------
  // Read value
  // ----------------------------------------------------------------
  always_comb begin
    p2_general = (p2_in & p2_dir_in) | (p2_latch_reg & ~p2_dir_in);
    rd_value   = bhp_pkg::BYTE_ZERO;
    unique case (evt.ap_index)
      bhp_pkg::IDX_PORT0: begin
        if (g0_strobed) begin
          rd_value = in_side ? in_buf_reg : p0_latch_reg;
        end else begin
          rd_value = cfg_reg.p0_in ? p0_in : p0_latch_reg;
        end
      end
      bhp_pkg::IDX_PORT1: begin
        rd_value = cfg_reg.p1_in ? p1_in : p1_latch_reg;
      end
      bhp_pkg::IDX_PORT2: begin
        rd_value = p2_general;
        if (g0_strobed) begin
          rd_value[bhp_pkg::P2_IRQ0] = group0_irq_request;
        end
        if (in_side) begin
          rd_value[bhp_pkg::P2_INPUT_STROBE_N] = hs_reg.rie;
          rd_value[bhp_pkg::P2_IN_BUF_FULL] = hs_reg.ibf;
        end
        if (out_side) begin
          rd_value[bhp_pkg::P2_ACK0] = hs_reg.wie;
          rd_value[bhp_pkg::P2_OUT_BUF_FULL_N] = hs_reg.obf_n;
        end
      end
      bhp_pkg::IDX_CMD: begin
        rd_value = bhp_pkg::BYTE_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Handshake and registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next         = cfg_reg;
    hs_next          = hs_reg;
    p0_latch_next    = p0_latch_reg;
    p1_latch_next    = p1_latch_reg;
    p2_latch_next    = p2_latch_reg;
    in_buf_next      = in_buf_reg;
    hs_next.rd_busy  = host_read_of_port0_start;
    hs_next.wr_busy  = host_write_to_port0_start;

    // Peripheral acknowledge takes the byte
    if (!data_ack_in_n) begin
      hs_next.obf_n = 1'b1;
      hs_next.taken = 1'b1;
    end
    // Strobe latches the pins
    if (stb_fall) begin
      in_buf_next = p0_in;
      hs_next.ibf = 1'b1;
    end
    if (host_read_of_port0_end && input_strobe_n && in_side) begin
      hs_next.ibf = 1'b0;
    end

    // Read start clears; a read in flight blocks the set
    if (host_read_of_port0_start) begin
      hs_next.rreq = 1'b0;
    end else if (hs_reg.rie && input_strobe_n && hs_reg.ibf && !hs_reg.rd_busy && in_side) begin
      hs_next.rreq = 1'b1;
    end
    // Write request waits for a taken byte and a quiet bus
    if (host_write_to_port0_start) begin
      hs_next.wreq  = 1'b0;
      hs_next.taken = 1'b0;
    end else if (hs_reg.wie && hs_reg.obf_n && data_ack_in_n && hs_reg.taken && !hs_reg.wr_busy &&
                 out_side) begin
      hs_next.wreq = 1'b1;
    end

    if (evt.wr_end && evt.dp_mapped) begin
      unique case (evt.dp_index)
        bhp_pkg::IDX_PORT0: begin
          p0_latch_next = evt.wdata;
          // A fresh byte outranks an acknowledge in the same cycle
          if (out_side) begin
            hs_next.obf_n = 1'b0;
          end
        end
        bhp_pkg::IDX_PORT1: begin
          p1_latch_next = evt.wdata;
        end
        bhp_pkg::IDX_PORT2: begin
          // Plain writes skip group 0 bits in strobed modes
          p2_latch_next = (p2_latch_reg & ~p2_plain_mask) | (evt.wdata & p2_plain_mask);
        end
        bhp_pkg::IDX_CMD: begin
          if (evt.wdata[bhp_pkg::CMD_MODE_SEL_BIT]) begin
            cfg_next      = decode_mode(evt.wdata);
            hs_next       = bhp_pkg::HS_RST;
            p0_latch_next = bhp_pkg::BYTE_ZERO;
            p1_latch_next = bhp_pkg::BYTE_ZERO;
            p2_latch_next = bhp_pkg::BYTE_ZERO;
            in_buf_next   = bhp_pkg::BYTE_ZERO;
          end else if (in_side && bmc_sel == bhp_pkg::P2_INPUT_STROBE_N) begin
            hs_next.rie = evt.wdata[bhp_pkg::BMC_VAL_BIT];
          end else if (out_side && bmc_sel == bhp_pkg::P2_ACK0) begin
            hs_next.wie = evt.wdata[bhp_pkg::BMC_VAL_BIT];
          end else begin
            p2_latch_next[bmc_sel] = evt.wdata[bhp_pkg::BMC_VAL_BIT];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg      <= bhp_pkg::CFG_RST;
      hs_reg       <= bhp_pkg::HS_RST;
      p0_latch_reg <= bhp_pkg::BYTE_ZERO;
      p1_latch_reg <= bhp_pkg::BYTE_ZERO;
      p2_latch_reg <= bhp_pkg::BYTE_ZERO;
      in_buf_reg   <= bhp_pkg::BYTE_ZERO;
    end else begin
      cfg_reg      <= cfg_next;
      hs_reg       <= hs_next;
      p0_latch_reg <= p0_latch_next;
      p1_latch_reg <= p1_latch_next;
      p2_latch_reg <= p2_latch_next;
      in_buf_reg   <= in_buf_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_comb begin
    p0_out_next = p0_latch_reg;
    p0_oe_next  = 1'b0;
    unique case (cfg_reg.g0_mode)
      bhp_pkg::BHP_G0_MODE0: p0_oe_next = ~cfg_reg.p0_in;
      bhp_pkg::BHP_G0_MODE1: p0_oe_next = out_side;
      bhp_pkg::BHP_G0_MODE2: p0_oe_next = ~data_ack_in_n;
    endcase
    p1_out_next = p1_latch_reg;
    p1_oe_next  = ~cfg_reg.p1_in;
    p2_out_next = p2_latch_reg;
    p2_oe_next  = ~p2_dir_in;
    if (g0_strobed) begin
      p2_out_next[bhp_pkg::P2_IRQ0] = group0_irq_request;
      p2_oe_next[bhp_pkg::P2_IRQ0]  = 1'b1;
    end
    if (in_side) begin
      // Strobe pin is input only; the read enable is never driven onto a pin
      p2_out_next[bhp_pkg::P2_INPUT_STROBE_N] = 1'b0;
      p2_oe_next[bhp_pkg::P2_INPUT_STROBE_N]  = 1'b0;
      p2_out_next[bhp_pkg::P2_IN_BUF_FULL] = hs_reg.ibf;
      p2_oe_next[bhp_pkg::P2_IN_BUF_FULL]  = 1'b1;
    end
    if (out_side) begin
      p2_out_next[bhp_pkg::P2_ACK0] = 1'b0;
      p2_oe_next[bhp_pkg::P2_ACK0]  = 1'b0;
      p2_out_next[bhp_pkg::P2_OUT_BUF_FULL_N] = hs_reg.obf_n;
      p2_oe_next[bhp_pkg::P2_OUT_BUF_FULL_N]  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      p0_out_reg <= bhp_pkg::BYTE_ZERO;
      p0_oe_reg  <= 1'b0;
      p1_out_reg <= bhp_pkg::BYTE_ZERO;
      p1_oe_reg  <= 1'b0;
      p2_out_reg <= bhp_pkg::BYTE_ZERO;
      p2_oe_reg  <= bhp_pkg::BYTE_ZERO;
    end else begin
      p0_out_reg <= p0_out_next;
      p0_oe_reg  <= p0_oe_next;
      p1_out_reg <= p1_out_next;
      p1_oe_reg  <= p1_oe_next;
      p2_out_reg <= p2_out_next;
      p2_oe_reg  <= p2_oe_next;
    end
  end

  assign p0_out = p0_out_reg;
  assign p0_oe  = p0_oe_reg;
  assign p1_out = p1_out_reg;
  assign p1_oe  = p1_oe_reg;
  assign p2_out = p2_out_reg;
  assign p2_oe  = p2_oe_reg;

endmodule : bhp_port_ctrl

/* File: pkg/bhp_pkg.sv */
// What this block does
// - Port 2 bit 3 is a group 1 general line only while group 0 is in mode 0.
// - Only group 0 may enter the bidirectional mode; group 1 never can.
// - Bidirectional mode: port 0 is one 8-bit two-way port steered by upper port 2 bits.
// - Port 2 bits 3..7 are request, strobe, input full, acknowledge, output full.
// - Port 2 read returns output full, input full, request and both enable flags.
// - Peripheral picks direction: acknowledge takes output, strobe delivers input.
// - Output-full low goes low when a host write to port 0 completes.
// - Output-full low returns high while the acknowledge input is low.
// - Write enable is set or cleared by bit manipulation; acknowledge input unaffected.
// - Strobe falling latches the port 0 pins into the input buffer.
// - Input-full rises at strobe fall, falls at end of port 0 read with strobe high.
// - Read enable is set or cleared by bit manipulation; strobe input unaffected.
// - Group 0 request is the OR of read-side and write-side requests.
// - Enable flags are internal and are never driven onto port 2 pins.
// - Unused strobed-mode group 0 bits stay general, changed only by bit manipulation.
// - Read request rises with enable, strobe, input-full high and no read; falls at read start.
// - Write request rises after taking, with enable, output-full, ack high; falls at write start.
// - Mode select and reset clear all port bits, handshake flags and requests.
package bhp_pkg;

  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_PORT0 = 2'h0;
  localparam logic [1:0] IDX_PORT1 = 2'h1;
  localparam logic [1:0] IDX_PORT2 = 2'h2;
  localparam logic [1:0] IDX_CMD   = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int unsigned CMD_MODE_SEL_BIT = 7;
  localparam int unsigned CMD_G0_MODE_HI   = 6;
  localparam int unsigned CMD_G0_MODE_LO   = 5;
  localparam int unsigned CMD_P0_IN_BIT    = 4;
  localparam int unsigned CMD_P2U_IN_BIT   = 3;
  localparam int unsigned CMD_P1_IN_BIT    = 1;
  localparam int unsigned CMD_P2L_IN_BIT   = 0;
  localparam int unsigned BMC_SEL_HI       = 3;
  localparam int unsigned BMC_SEL_LO       = 1;
  localparam int unsigned BMC_VAL_BIT      = 0;

  // ----------------------------------------------------------------
  // Port 2 bit roles for group 0
  // ----------------------------------------------------------------
  localparam logic [2:0] P2_IRQ0 = 3'h3;
  localparam logic [2:0] P2_INPUT_STROBE_N = 3'h4;
  localparam logic [2:0] P2_IN_BUF_FULL = 3'h5;
  localparam logic [2:0] P2_ACK0 = 3'h6;
  localparam logic [2:0] P2_OUT_BUF_FULL_N = 3'h7;
  localparam int unsigned P2_UPPER_LO = 4;
  localparam logic [7:0] P2_G1_MASK  = 8'h07;
  localparam logic [7:0] P2_ALL_MASK = 8'hFF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  typedef enum logic [2:0] {
    BHP_G0_MODE0 = 3'b001,
    BHP_G0_MODE1 = 3'b010,
    BHP_G0_MODE2 = 3'b100
  } bhp_g0_mode_t;

  typedef struct packed {
    bhp_g0_mode_t g0_mode;
    logic         p0_in;
    logic         p2u_in;
    logic         p1_in;
    logic         p2l_in;
  } bhp_cfg_t;

  localparam bhp_cfg_t CFG_RST = '{g0_mode: BHP_G0_MODE0, p0_in: 1'b1, p2u_in: 1'b1,
                                   p1_in: 1'b1, p2l_in: 1'b1};

  typedef struct packed {
    logic obf_n;
    logic ibf;
    logic rie;
    logic wie;
    logic rreq;
    logic wreq;
    logic taken;
    logic rd_busy;
    logic wr_busy;
  } bhp_hs_t;

  localparam bhp_hs_t HS_RST = '{obf_n: 1'b1, default: 1'b0};

  typedef struct packed {
    logic       rd_start;
    logic       wr_start;
    logic [1:0] ap_index;
    logic       ap_mapped;
    logic       rd_end;
    logic       wr_end;
    logic [1:0] dp_index;
    logic       dp_mapped;
    logic [7:0] wdata;
  } bhp_bus_evt_t;

endpackage : bhp_pkg

/* File: tb/bhp_assertions.sv */
`timescale 1ns/1ps
module bhp_assertions (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [7:0]  p2_in,
  input wire logic [7:0]  p2_out,
  input wire logic [7:0]  p2_oe,
  input wire logic        p0_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Both full-flag pins driven in the two-way mode, or in mode 0 or 1 with upper port 2 as output
  wire logic m2 = p2_oe[5] & p2_oe[7];
  rst_clear_a: assert property ($rose(arst_n) |-> p2_oe == 8'h00 && !p0_oe)
    else $error("pins driven right after reset");
  irq_pin_a: assert property (m2 |-> p2_oe[3])
    else $error("request pin not driven");
  flag_hide_a: assert property (m2 |-> !p2_oe[4] && !p2_oe[6])
    else $error("enable flag driven onto a pin");
  ibf_rise_a: assert property (m2 && $fell(p2_in[4]) |-> ##[1:3] p2_out[5])
    else $error("input full did not rise after strobe");
  obf_clear_a: assert property (m2 && !p2_in[6] |-> ##[1:3] p2_out[7])
    else $error("output full not cleared by acknowledge");
  p0_drive_a: assert property (m2 && p0_oe |-> !$past(p2_in[6]))
    else $error("port 0 driven without acknowledge");
  ack_steer_a: assert property (m2 && !p2_in[6] |=> p0_oe)
    else $error("acknowledge did not turn port 0 to output");
  irq_cause_a: assert property (m2 && $rose(p2_out[3]) |-> p2_out[5] || p2_out[7])
    else $error("request rose with no cause");
endmodule : bhp_assertions
bind bhp_port_ctrl bhp_assertions u_chk (.clk_sys, .arst_n, .p2_in, .p2_out, .p2_oe, .p0_oe);

/* File: tb/bhp_peer.sv */
`timescale 1ns/1ps
module bhp_peer (
  input wire logic       clk_sys,
  input wire logic [7:0] p0_out,
  input wire logic       p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  output logic [7:0]     p0_in,
  output logic [7:0]     p2_in
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic       on = 1'b0;
  logic       stb_n = 1'b1;
  logic       ack_n = 1'b1;
  // Released lines toggle so a stale value can never pass
  always_ff @(posedge clk_sys) last <= p0_in;
  always_comb p0_in = p0_oe ? p0_out : (on ? drv : ~last);
  always_comb p2_in = ((p2_out ^ ~p2_oe) & 8'hAF) | {1'b0, ack_n, 1'b0, stb_n, 4'h0};
  task put(input logic [7:0] d, input int hold);
    drv <= d;
    on <= 1'b1;
    stb_n <= 1'b0;
    repeat (hold) @(posedge clk_sys);
    stb_n <= 1'b1;
    @(posedge clk_sys);
    on <= 1'b0;
  endtask : put
  task take(input int hold, output logic [7:0] d, output logic to);
    int n;
    n = 0;
    while (p2_out[7] !== 1'b0 && n < 64) begin
      @(posedge clk_sys);
      n++;
    end
    to = (p2_out[7] !== 1'b0);
    ack_n <= 1'b0;
    repeat (hold) @(posedge clk_sys);
    d = p0_in;
    ack_n <= 1'b1;
  endtask : take
endmodule : bhp_peer

/* File: tb/bhp_port_ctrl_test.sv */
`timescale 1ns/1ps
module bhp_port_ctrl_test;
  logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, p0_oe, p1_oe, tmo;
  logic [7:0] haddr = 8'h00, p0_in, p0_out, p1_in, p1_out, p2_in, p2_out, p2_oe, b;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = bhp_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, q;
  int n_fail = 0, cmp_count = 0;
  assign p1_in = ~p1_out;
  bhp_port_ctrl u_dut (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .p0_in, .p0_out, .p0_oe, .p1_in, .p1_out, .p1_oe,
    .p2_in, .p2_out, .p2_oe);
  bhp_peer u_peer (.clk_sys, .p0_out, .p0_oe, .p2_out, .p2_oe, .p0_in, .p2_in);
  initial forever #12.5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      print_verdict;
    end
  endtask : rdy
  task xfer(input logic w, input logic [1:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {4'h0, idx, 2'h0};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    rdy;
    q = hrdata;
  endtask : xfer
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 8'h10;
    hwrite <= 1'b0;
    rdy;
    htrans <= 2'h0;
    rdy;
    chk("unmapped read", hrdata, 32'h0000_0000);
    chk("reset p2_oe", {24'h00_0000, p2_oe}, 32'h0000_0000);
    chk("reset p0_oe hresp", 32'({p0_oe, hresp}), 32'h0000_0000);
    xfer(1'b0, bhp_pkg::IDX_PORT2, 8'h00);
    chk("mode0 port2 read", q, 32'h0000_00FF);
  endtask : t_reset
  task t_mode;
    xfer(1'b1, bhp_pkg::IDX_CMD, 8'hC0);
    cyc(2);
    chk("mode2 p2_oe", {24'h00_0000, p2_oe}, 32'h0000_00AF);
    chk("mode2 flags", 32'({p2_out[7], p2_out[5], p2_out[3]}), 32'h0000_0004);
    chk("mode2 port1", 32'({p1_oe, p1_out}), 32'h0000_0100);
  endtask : t_mode
  task t_out(input logic [7:0] d, input int hold);
    xfer(1'b1, bhp_pkg::IDX_PORT0, d);
    cyc(2);
    chk("obf after write", 32'(p2_out[7]), 32'h0000_0000);
    u_peer.take(hold, b, tmo);
    if (tmo) begin
      n_fail++;
      print_verdict;
    end
    chk("output byte", 32'(b), {24'h00_0000, d});
    cyc(2);
    chk("obf after ack", 32'(p2_out[7]), 32'h0000_0001);
  endtask : t_out
  task t_in;
    xfer(1'b1, bhp_pkg::IDX_CMD, 8'h09);
    u_peer.put(8'hC3, 2);
    cyc(3);
    chk("ibf and irq", 32'({p2_out[5], p2_out[3]}), 32'h0000_0003);
    xfer(1'b0, bhp_pkg::IDX_PORT2, 8'h00);
    chk("port2 status", 32'(q[7:3]), 32'h0000_0017);
    xfer(1'b0, bhp_pkg::IDX_PORT0, 8'h00);
    chk("input byte", q, 32'h0000_00C3);
    cyc(2);
    chk("ibf irq cleared", 32'({p2_out[5], p2_out[3]}), 32'h0000_0000);
  endtask : t_in
  task t_wirq;
    xfer(1'b1, bhp_pkg::IDX_CMD, 8'h0D);
    cyc(3);
    chk("write request", 32'(p2_out[3]), 32'h0000_0001);
    xfer(1'b0, bhp_pkg::IDX_PORT2, 8'h00);
    chk("wie readback", 32'(q[6]), 32'h0000_0001);
    t_out(8'h3C, 3);
  endtask : t_wirq
  task t_bits;
    xfer(1'b1, bhp_pkg::IDX_PORT2, 8'hFF);
    cyc(2);
    chk("plain port2 write", 32'({p2_out[7], p2_out[5], p2_out[2:0]}), 32'h0000_0017);
    xfer(1'b1, bhp_pkg::IDX_CMD, 8'hC0);
    cyc(2);
    chk("mode reselect", 32'({p2_out[7], p2_out[5], p2_out[3:0]}), 32'h0000_0020);
  endtask : t_bits
  initial begin
    #1_000_000;
    n_fail++;
    print_verdict;
  end
  initial begin
    cyc(16);
    arst_n <= 1'b1;
    t_reset;
    t_mode;
    t_out(8'h5A, 3);
    t_out(8'hA5, 8);
    t_in;
    t_wirq;
    t_bits;
    print_verdict;
  end
endmodule : bhp_port_ctrl_test
